// ### rtl/isp_port.sv
// Serial in-system programming port with its Flash, EEPROM, fuse and lock storage
`timescale 1ns/1ps

// How it works
// - Only programming enable is obeyed until enable has completed after reset low.
// - MOSI bits are taken on each rising edge of the sampled SCK.
// - MISO bits change on each falling edge of the sampled SCK.
// - Enable is AC 53 00 00; byte two echoes during byte three.
// - Flash page buffer loads low byte 40 and high byte 48 by word.
// - Opcode 4C writes the page buffer into the addressed Flash page.
// - Opcode C0 erases then writes one EEPROM byte as one timed operation.
// - C1 loads EEPROM page bytes, C2 writes only the loaded ones.
// - Chip erase sets all Flash and EEPROM locations to FF.
// - Poll F0 returns busy in bit zero while an operation is pending.
// - Reads 20, 28 and A0 return memory content during byte four.
// - Reads 58 and 50 with byte two 00 or 08 return lock and fuses.
// - AC with E0, A0, A8, A4 writes lock, low, high, extended fuses.
// - Opcode 4D latches byte three as the extended address byte.
// - Reset pin high ends the session and starts normal operation.
module isp_port
    import isp_port_pkg::*;
#(
    parameter int FLASH_AW = 12,
    parameter int FLASH_PAGE_AW = 5,
    parameter int EE_AW = 9,
    parameter int EE_PAGE_AW = 2,
    parameter int FLASH_WAIT_CYC = FLASH_WRITE_WAIT_CYC,
    parameter int EE_WAIT_CYC = EEPROM_WRITE_WAIT_CYC,
    parameter int ERASE_WAIT_CYC = CHIP_ERASE_WAIT_CYC,
    parameter int FUSE_WAIT_CYC = FUSE_WRITE_WAIT_CYC,
    // Arbitrary neutral identification values
    parameter logic [23:0] SIGNATURE = 24'h010203,
    parameter logic [7:0] CALIBRATION = 8'h80
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Programming pins
    input wire logic rst_pin_i,
    input wire logic sck_i,
    input wire logic mosi_i,
    output logic miso_o,
    // Status
    output logic prog_enabled_o,
    output logic busy_o,
    output logic normal_mode_o,
    // Configuration bytes
    output logic [7:0] fuse_low_o,
    output logic [7:0] fuse_high_o,
    output logic [7:0] fuse_ext_o,
    output logic [7:0] lock_bits_o
);
    localparam int FLASH_WORDS = 1 << FLASH_AW;
    localparam int EE_BYTES = 1 << EE_AW;
    localparam int FPAGE = 1 << FLASH_PAGE_AW;
    localparam int EPAGE = 1 << EE_PAGE_AW;

    if (FLASH_AW > 16 || EE_AW > 16 || FLASH_PAGE_AW >= FLASH_AW || EE_PAGE_AW >= EE_AW
        || FLASH_WAIT_CYC < 2 || EE_WAIT_CYC < 2 || ERASE_WAIT_CYC < 2 || FUSE_WAIT_CYC < 2
        || FLASH_WAIT_CYC >= (1 << WAIT_W) || FUSE_WAIT_CYC >= (1 << WAIT_W)
        || EE_WAIT_CYC >= (1 << WAIT_W) || ERASE_WAIT_CYC >= (1 << WAIT_W))
    begin : bad_params
        $error("isp_port: unsupported parameter values");
    end

    // ---------------------------------------------------------------
    // Pin synchronisers and SCK edge detection
    // ---------------------------------------------------------------
    logic [2:0] pins_s1;
    logic [2:0] pins_s2;
    logic sck_d;
    logic rst_s;
    logic sck_s;
    logic mosi_s;
    logic prog_pin;
    logic sck_rise;
    logic sck_fall;

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pins_s1 <= 3'h1;
            pins_s2 <= 3'h1;
            sck_d <= 1'b0;
        end
        else
        begin
            pins_s1 <= {sck_i, mosi_i, rst_pin_i};
            pins_s2 <= pins_s1;
            sck_d <= pins_s2[2];
        end
    end

    assign rst_s = pins_s2[0];
    assign mosi_s = pins_s2[1];
    assign sck_s = pins_s2[2];
    assign prog_pin = !rst_s;
    assign sck_rise = prog_pin && sck_s && !sck_d;
    assign sck_fall = prog_pin && !sck_s && sck_d;

    // ---------------------------------------------------------------
    // Shift registers
    // ---------------------------------------------------------------
    logic [4:0] bit_cnt;
    logic [31:0] word;
    logic [31:0] next_word;
    logic [7:0] out_sr;
    logic [7:0] read_data;
    logic byte_done;
    logic exec;

    assign next_word = {word[30:0], mosi_s};
    assign byte_done = sck_rise && (bit_cnt[2:0] == BYTE_LAST_BIT);
    assign exec = sck_rise && (bit_cnt == LAST_BIT);

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            bit_cnt <= 5'h00;
            word <= 32'h0000_0000;
        end
        else if (!prog_pin)
        begin
            bit_cnt <= 5'h00;
            word <= 32'h0000_0000;
        end
        else if (sck_rise)
        begin
            bit_cnt <= bit_cnt + 5'h01;
            word <= next_word;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            out_sr <= 8'h00;
        else if (!prog_pin)
            out_sr <= 8'h00;
        else if (byte_done)
            out_sr <= (bit_cnt[4:3] == 2'h2) ? read_data :
                      (bit_cnt[4:3] == 2'h3) ? 8'h00 : next_word[7:0];
        else if (sck_fall)
            out_sr <= {out_sr[6:0], 1'b0};
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            miso_o <= 1'b0;
        else if (!prog_pin)
            miso_o <= 1'b0;
        else if (sck_fall)
            miso_o <= out_sr[7];
    end

    // ---------------------------------------------------------------
    // Storage and configuration state
    // ---------------------------------------------------------------
    logic [7:0] flash_lo [FLASH_WORDS];
    logic [7:0] flash_hi [FLASH_WORDS];
    logic [7:0] ee_mem [EE_BYTES];
    logic [7:0] fbuf_lo [FPAGE];
    logic [7:0] fbuf_hi [FPAGE];
    logic [7:0] ee_buf [EPAGE];
    logic [EPAGE-1:0] ee_loaded;
    logic [7:0] ext_addr;
    logic enabled;
    logic busy;
    logic [WAIT_W-1:0] busy_cnt;

    // Read decode works on bytes one to three as byte three completes
    logic [7:0] rd_op;
    logic [7:0] rd_b2;
    logic [7:0] rd_b3;
    logic [FLASH_AW-1:0] rd_faddr;
    logic [EE_AW-1:0] rd_eaddr;
    logic mem_hidden;

    assign rd_op = next_word[23:16];
    assign rd_b2 = next_word[15:8];
    assign rd_b3 = next_word[7:0];
    assign rd_faddr = next_word[FLASH_AW-1:0];
    assign rd_eaddr = next_word[EE_AW-1:0];
    // Read-back is blocked once the second lock bit is programmed
    assign mem_hidden = !lock_bits_o[LOCK_LB2_BIT];

    always_comb
    begin
        read_data = 8'h00;
        if (enabled)
        begin
            case (rd_op)
                OP_READ_LOW: read_data = mem_hidden ? ERASED_BYTE : flash_lo[rd_faddr];
                OP_READ_HIGH: read_data = mem_hidden ? ERASED_BYTE : flash_hi[rd_faddr];
                OP_EE_READ: read_data = mem_hidden ? ERASED_BYTE : ee_mem[rd_eaddr];
                OP_READ_LOCK_FHIGH: read_data = (rd_b2 == SEL_HIGH) ? fuse_high_o : lock_bits_o;
                OP_READ_FUSE: read_data = (rd_b2 == SEL_HIGH) ? fuse_ext_o : fuse_low_o;
                OP_READ_SIG: read_data = SIGNATURE[8 * (2 - int'(rd_b3[1:0] % 3)) +: 8];
                OP_READ_CAL: read_data = CALIBRATION;
                OP_POLL: read_data = {7'h00, busy};
                default: read_data = 8'h00;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Instruction execution on the 32nd rising edge
    // ---------------------------------------------------------------
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b4;
    logic [FLASH_AW-1:0] faddr;
    logic [EE_AW-1:0] eaddr;
    logic go;
    logic mem_ok;
    logic do_enable;
    logic do_erase;
    logic do_fload_lo;
    logic do_fload_hi;
    logic do_fwrite;
    logic do_ee_write;
    logic do_ee_load;
    logic do_ee_page;
    logic do_fuse;
    logic do_ext;

    assign op = next_word[31:24];
    assign b2 = next_word[23:16];
    assign b4 = next_word[7:0];
    assign faddr = next_word[FLASH_AW+7:8];
    assign eaddr = next_word[EE_AW+7:8];
    assign go = exec && enabled && !busy;
    // Lock bit 1 freezes memories and fuses; erase stays allowed
    assign mem_ok = go && lock_bits_o[LOCK_LB1_BIT];

    always_comb
    begin
        do_enable = exec && (op == OP_PREFIX) && (b2 == SUB_ENABLE);
        do_erase = go && (op == OP_PREFIX) && (b2 == SUB_ERASE);
        do_fuse = mem_ok && (op == OP_PREFIX) && (b2 inside {SUB_WRITE_FUSE_LOW,
                  SUB_WRITE_FUSE_HIGH, SUB_WRITE_FUSE_EXT, SUB_WRITE_LOCK});
        do_fload_lo = mem_ok && (op == OP_LOAD_LOW);
        do_fload_hi = mem_ok && (op == OP_LOAD_HIGH);
        do_fwrite = mem_ok && (op == OP_PAGE_WRITE);
        do_ee_write = mem_ok && (op == OP_EE_WRITE);
        do_ee_load = mem_ok && (op == OP_EE_LOAD);
        do_ee_page = mem_ok && (op == OP_EE_PAGE_WRITE);
        do_ext = go && (op == OP_EXT_ADDR);
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            for (int i = 0; i < FLASH_WORDS; i++)
            begin
                flash_lo[i] <= ERASED_BYTE;
                flash_hi[i] <= ERASED_BYTE;
            end
            for (int i = 0; i < EE_BYTES; i++)
                ee_mem[i] <= ERASED_BYTE;
            for (int i = 0; i < FPAGE; i++)
            begin
                fbuf_lo[i] <= ERASED_BYTE;
                fbuf_hi[i] <= ERASED_BYTE;
            end
            for (int i = 0; i < EPAGE; i++)
                ee_buf[i] <= ERASED_BYTE;
            ee_loaded <= '0;
        end
        else if (do_erase)
        begin
            for (int i = 0; i < FLASH_WORDS; i++)
            begin
                flash_lo[i] <= ERASED_BYTE;
                flash_hi[i] <= ERASED_BYTE;
            end
            for (int i = 0; i < EE_BYTES; i++)
                ee_mem[i] <= ERASED_BYTE;
        end
        else if (do_fload_lo)
            fbuf_lo[faddr[FLASH_PAGE_AW-1:0]] <= b4;
        else if (do_fload_hi)
            fbuf_hi[faddr[FLASH_PAGE_AW-1:0]] <= b4;
        else if (do_fwrite)
        begin
            for (int i = 0; i < FPAGE; i++)
            begin
                flash_lo[{faddr[FLASH_AW-1:FLASH_PAGE_AW], FLASH_PAGE_AW'(i)}] <= fbuf_lo[i];
                flash_hi[{faddr[FLASH_AW-1:FLASH_PAGE_AW], FLASH_PAGE_AW'(i)}] <= fbuf_hi[i];
                fbuf_lo[i] <= ERASED_BYTE;
                fbuf_hi[i] <= ERASED_BYTE;
            end
        end
        else if (do_ee_write)
            ee_mem[eaddr] <= b4;
        else if (do_ee_load)
        begin
            ee_buf[eaddr[EE_PAGE_AW-1:0]] <= b4;
            ee_loaded[eaddr[EE_PAGE_AW-1:0]] <= 1'b1;
        end
        else if (do_ee_page)
        begin
            for (int i = 0; i < EPAGE; i++)
                if (ee_loaded[i])
                    ee_mem[{eaddr[EE_AW-1:EE_PAGE_AW], EE_PAGE_AW'(i)}] <= ee_buf[i];
            ee_loaded <= '0;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            fuse_low_o <= FUSE_LOW_RST;
            fuse_high_o <= FUSE_HIGH_RST;
            fuse_ext_o <= FUSE_EXT_RST;
            lock_bits_o <= LOCK_RST;
            ext_addr <= 8'h00;
        end
        else if (do_erase)
            lock_bits_o <= LOCK_RST;
        else if (do_ext)
            ext_addr <= next_word[15:8];
        else if (do_fuse)
        begin
            case (b2)
                SUB_WRITE_FUSE_LOW: fuse_low_o <= b4;
                SUB_WRITE_FUSE_HIGH: fuse_high_o <= b4;
                SUB_WRITE_FUSE_EXT: fuse_ext_o <= b4;
                // Lock bits only move towards programmed
                default: lock_bits_o <= lock_bits_o & b4;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            enabled <= 1'b0;
            prog_enabled_o <= 1'b0;
            normal_mode_o <= 1'b0;
        end
        else
        begin
            normal_mode_o <= rst_s;
            if (!prog_pin)
                enabled <= 1'b0;
            else if (do_enable)
                enabled <= 1'b1;
            prog_enabled_o <= enabled;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            busy_cnt <= '0;
            busy <= 1'b0;
        end
        else if (do_erase || do_fwrite || do_ee_write || do_ee_page || do_fuse)
        begin
            busy <= 1'b1;
            busy_cnt <= do_erase ? WAIT_W'(ERASE_WAIT_CYC) :
                        do_fwrite ? WAIT_W'(FLASH_WAIT_CYC) :
                        do_fuse ? WAIT_W'(FUSE_WAIT_CYC) : WAIT_W'(EE_WAIT_CYC);
        end
        else if (busy_cnt != '0)
        begin
            busy_cnt <= busy_cnt - WAIT_W'(1);
            busy <= (busy_cnt != WAIT_W'(1));
        end
    end

    assign busy_o = busy;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    sequence byte3_done;
        byte_done && (bit_cnt[4:3] == 2'h2);
    endsequence

    sequence busy_run;
        busy [*8];
    endsequence

    refuse_unenabled_a: assert property (exec && !enabled |=> !busy && lock_bits_o == $past(lock_bits_o))
        else $error("instruction obeyed before enable");
    rise_sample_a: assert property (sck_rise |=> word[0] == $past(mosi_s) && bit_cnt == $past(bit_cnt) + 5'h01)
        else $error("MOSI bit not taken on rise");
    miso_on_fall_a: assert property (miso_o != $past(miso_o) |-> $past(sck_fall) || $past(!prog_pin))
        else $error("MISO changed outside a falling edge");
    echo_byte2_a: assert property (byte_done && bit_cnt[4:3] == 2'h1 |=> out_sr == $past(next_word[7:0]))
        else $error("byte two not echoed");
    enable_takes_a: assert property (do_enable |=> enabled ##1 prog_enabled_o)
        else $error("enable instruction not taken");
    flash_busy_a: assert property (do_fwrite |=> busy_run)
        else $error("page write not self-timed");
    ee_byte_a: assert property (do_ee_write |=> ee_mem[$past(eaddr)] == $past(b4) && busy)
        else $error("EEPROM byte not written");
    erase_all_a: assert property (do_erase |=> flash_lo[0] == ERASED_BYTE && ee_mem[EE_BYTES-1] == ERASED_BYTE && lock_bits_o == LOCK_RST && $stable(fuse_low_o))
        else $error("chip erase incomplete");
    poll_bit_a: assert property (byte3_done ##0 (rd_op == OP_POLL && enabled) |=> out_sr[0] == $past(busy))
        else $error("poll bit wrong");
    fuse_write_a: assert property (do_fuse && b2 == SUB_WRITE_FUSE_HIGH |=> fuse_high_o == $past(b4))
        else $error("high fuse not written");
    ext_latch_a: assert property (do_ext |=> ext_addr == $past(next_word[15:8]))
        else $error("extended address not latched");
    leave_prog_a: assert property (!prog_pin [*2] |=> !enabled && !prog_enabled_o && normal_mode_o)
        else $error("session not ended by reset high");
endmodule : isp_port

// ### rtl/isp_port_pkg.sv
// Constants shared by the serial programming port: opcodes, reset values and wait times
package isp_port_pkg;
    // ---------------------------------------------------------------
    // Instruction opcodes (byte 1) and sub-codes (byte 2)
    // ---------------------------------------------------------------
    localparam logic [7:0] OP_PREFIX = 8'hAC;
    localparam logic [7:0] SUB_ENABLE = 8'h53;
    localparam logic [7:0] SUB_ERASE = 8'h80;
    localparam logic [7:0] SUB_WRITE_LOCK = 8'hE0;
    localparam logic [7:0] SUB_WRITE_FUSE_LOW = 8'hA0;
    localparam logic [7:0] SUB_WRITE_FUSE_HIGH = 8'hA8;
    localparam logic [7:0] SUB_WRITE_FUSE_EXT = 8'hA4;
    localparam logic [7:0] OP_POLL = 8'hF0;
    localparam logic [7:0] OP_EXT_ADDR = 8'h4D;
    localparam logic [7:0] OP_LOAD_LOW = 8'h40;
    localparam logic [7:0] OP_LOAD_HIGH = 8'h48;
    localparam logic [7:0] OP_PAGE_WRITE = 8'h4C;
    localparam logic [7:0] OP_READ_LOW = 8'h20;
    localparam logic [7:0] OP_READ_HIGH = 8'h28;
    localparam logic [7:0] OP_EE_READ = 8'hA0;
    localparam logic [7:0] OP_EE_WRITE = 8'hC0;
    localparam logic [7:0] OP_EE_LOAD = 8'hC1;
    localparam logic [7:0] OP_EE_PAGE_WRITE = 8'hC2;
    localparam logic [7:0] OP_READ_LOCK_FHIGH = 8'h58;
    localparam logic [7:0] OP_READ_FUSE = 8'h50;
    localparam logic [7:0] OP_READ_SIG = 8'h30;
    localparam logic [7:0] OP_READ_CAL = 8'h38;
    localparam logic [7:0] SEL_HIGH = 8'h08;

    // ---------------------------------------------------------------
    // Reset values and bit positions
    // ---------------------------------------------------------------
    localparam logic [7:0] FUSE_LOW_RST = 8'h62;
    localparam logic [7:0] FUSE_HIGH_RST = 8'hDF;
    localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int LOCK_LB1_BIT = 0;
    localparam int LOCK_LB2_BIT = 1;
    localparam logic [4:0] LAST_BIT = 5'h1F;
    localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

    // ---------------------------------------------------------------
    // Timing: busy periods
    // ---------------------------------------------------------------
    localparam int CLK_FREQ_KHZ = 25000;
    localparam int FLASH_WRITE_WAIT_US = 4500;
    localparam int EEPROM_WRITE_WAIT_US = 4000;
    localparam int CHIP_ERASE_WAIT_US = 4000;
    localparam int FUSE_WRITE_WAIT_US = 4500;
    localparam int FLASH_WRITE_WAIT_CYC = (FLASH_WRITE_WAIT_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int EEPROM_WRITE_WAIT_CYC = (EEPROM_WRITE_WAIT_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int CHIP_ERASE_WAIT_CYC = (CHIP_ERASE_WAIT_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int FUSE_WRITE_WAIT_CYC = (FUSE_WRITE_WAIT_US * CLK_FREQ_KHZ + 999) / 1000;
    localparam int WAIT_W = 24;
endpackage : isp_port_pkg

// ### bench/isp_programmer.sv
// Behavioural serial programmer that drives SCK and MOSI and captures MISO
`timescale 1ns/1ps
module isp_programmer (
    // Clock
    input wire logic clk_i,
    // Serial link
    input wire logic miso_i,
    output logic sck_o,
    output logic mosi_o
);
    initial sck_o = 1'b0;
    initial mosi_o = 1'b0;

    // ---------------------------------------------------------------
    // One 32-bit frame
    // ---------------------------------------------------------------
    // MSB first, whole frame
    task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--)
        begin
            @(posedge clk_i);
            #1 mosi_o = tx[i];
            repeat (4) @(posedge clk_i);
            #1 rx[i] = miso_i;
            sck_o = 1'b1;
            repeat (4) @(posedge clk_i);
            #1 sck_o = 1'b0;
        end
        // Released line must not look like held data
        @(posedge clk_i);
        #1 mosi_o = ~mosi_o;
    endtask : frame
endmodule : isp_programmer

// ### bench/isp_port_tb_top.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
module isp_port_tb_top
    import isp_port_pkg::*;
;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic rst_pin_i = 1'b0;
    logic sck, mosi, miso, prog_enabled, busy, normal_mode;
    logic [7:0] fuse_low, fuse_high, fuse_ext, lock_bits;
    logic [31:0] rd;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    always #20 clk_i = ~clk_i;

    // Long waits shortened so a poll can still see busy
    isp_port #(.FLASH_WAIT_CYC(600), .EE_WAIT_CYC(600), .ERASE_WAIT_CYC(600),
        .FUSE_WAIT_CYC(600)) isp_port_i (
        .clk_i(clk_i), .resetn_i(resetn_i), .rst_pin_i(rst_pin_i), .sck_i(sck),
        .mosi_i(mosi), .miso_o(miso), .prog_enabled_o(prog_enabled), .busy_o(busy),
        .normal_mode_o(normal_mode), .fuse_low_o(fuse_low), .fuse_high_o(fuse_high),
        .fuse_ext_o(fuse_ext), .lock_bits_o(lock_bits));

    isp_programmer isp_programmer_i (.clk_i(clk_i), .miso_i(miso), .sck_o(sck),
        .mosi_o(mosi));

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
            mismatches++;
        end
    endtask : chk

    task automatic cmd(input logic [7:0] b1, b2, b3, b4);
        isp_programmer_i.frame({b1, b2, b3, b4}, rd);
    endtask : cmd

    task automatic idle();
        rd = 32'h1;
        repeat (8) if (rd[0] !== 1'b0) cmd(OP_POLL, 8'h00, 8'h00, 8'h00);
        chk({7'h00, rd[0]}, 8'h00);
    endtask : idle

    task automatic print_verdict();
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic locked_out();
        cmd(OP_PREFIX, SUB_WRITE_FUSE_LOW, 8'h00, 8'h00);
        cmd(OP_READ_FUSE, 8'h00, 8'h00, 8'h00);
        chk(rd[7:0], 8'h00);
        chk(fuse_low, FUSE_LOW_RST);
        chk({7'h00, prog_enabled}, 8'h00);
    endtask : locked_out

    task automatic enable_port();
        cmd(OP_PREFIX, SUB_ENABLE, 8'h00, 8'h00);
        chk(rd[23:16], OP_PREFIX);
        chk(rd[15:8], SUB_ENABLE);
        repeat (3) @(posedge clk_i);
        chk({7'h00, prog_enabled}, 8'h01);
    endtask : enable_port

    task automatic config_io();
        logic [7:0] sub[3] = '{SUB_WRITE_FUSE_LOW, SUB_WRITE_FUSE_HIGH, SUB_WRITE_FUSE_EXT};
        logic [7:0] rop[3] = '{OP_READ_FUSE, OP_READ_LOCK_FHIGH, OP_READ_FUSE};
        logic [7:0] sel[3] = '{8'h00, SEL_HIGH, SEL_HIGH};
        logic [7:0] rst[3] = '{FUSE_LOW_RST, FUSE_HIGH_RST, FUSE_EXT_RST};
        logic [7:0] val[3] = '{8'hA2, 8'hD7, 8'hFE};
        logic [23:0] outs;
        cmd(OP_READ_LOCK_FHIGH, 8'h00, 8'h00, 8'h00);
        chk(rd[7:0], LOCK_RST);
        for (int k = 0; k < 3; k++)
        begin
            cmd(rop[k], sel[k], 8'h00, 8'h00);
            chk(rd[7:0], rst[k]);
            cmd(OP_PREFIX, sub[k], 8'h00, val[k]);
            repeat (2) @(posedge clk_i);
            chk({7'h00, busy}, 8'h01);
            cmd(OP_POLL, 8'h00, 8'h00, 8'h00);
            chk({7'h00, rd[0]}, 8'h01);
            idle();
            outs = {fuse_low, fuse_high, fuse_ext};
            chk(outs[23 - 8 * k -: 8], val[k]);
            cmd(rop[k], sel[k], 8'h00, 8'h00);
            chk(rd[7:0], val[k]);
        end
    endtask : config_io

    task automatic flash_page();
        cmd(OP_EXT_ADDR, 8'h00, 8'h00, 8'h00);
        cmd(OP_LOAD_LOW, 8'h00, 8'h05, 8'h12);
        cmd(OP_LOAD_HIGH, 8'h00, 8'h05, 8'h34);
        cmd(OP_PAGE_WRITE, 8'h00, 8'h00, 8'h00);
        idle();
        cmd(OP_READ_LOW, 8'h00, 8'h05, 8'h00);
        chk(rd[7:0], 8'h12);
        cmd(OP_READ_HIGH, 8'h00, 8'h05, 8'h00);
        chk(rd[7:0], 8'h34);
        cmd(OP_READ_LOW, 8'h00, 8'h06, 8'h00);
        chk(rd[7:0], ERASED_BYTE);
    endtask : flash_page

    task automatic eeprom_io();
        cmd(OP_EE_WRITE, 8'h00, 8'h02, 8'h5A);
        idle();
        cmd(OP_EE_LOAD, 8'h00, 8'h01, 8'h77);
        cmd(OP_EE_PAGE_WRITE, 8'h00, 8'h00, 8'h00);
        idle();
        cmd(OP_EE_READ, 8'h00, 8'h02, 8'h00);
        chk(rd[7:0], 8'h5A);
        cmd(OP_EE_READ, 8'h00, 8'h01, 8'h00);
        chk(rd[7:0], 8'h77);
    endtask : eeprom_io

    task automatic lock_io();
        // unused lock bits left at one
        cmd(OP_PREFIX, SUB_WRITE_LOCK, 8'h00, 8'hFC);
        idle();
        chk(lock_bits, 8'hFC);
        cmd(OP_READ_LOCK_FHIGH, 8'h00, 8'h00, 8'h00);
        chk(rd[7:0], 8'hFC);
        // Programmed lock bits refuse fuse writes and hide memory
        cmd(OP_PREFIX, SUB_WRITE_FUSE_LOW, 8'h00, 8'h00);
        repeat (2) @(posedge clk_i);
        chk({7'h00, busy}, 8'h00);
        chk(fuse_low, 8'hA2);
        cmd(OP_READ_LOW, 8'h00, 8'h05, 8'h00);
        chk(rd[7:0], ERASED_BYTE);
    endtask : lock_io

    task automatic erase_all();
        cmd(OP_PREFIX, SUB_ERASE, 8'h00, 8'h00);
        idle();
        chk(lock_bits, LOCK_RST);
        cmd(OP_READ_HIGH, 8'h00, 8'h05, 8'h00);
        chk(rd[7:0], ERASED_BYTE);
        cmd(OP_EE_READ, 8'h00, 8'h02, 8'h00);
        chk(rd[7:0], ERASED_BYTE);
    endtask : erase_all

    task automatic end_session();
        @(posedge clk_i);
        #1 rst_pin_i = 1'b1;
        repeat (6) @(posedge clk_i);
        chk({7'h00, normal_mode}, 8'h01);
        chk({7'h00, prog_enabled}, 8'h00);
    endtask : end_session

    // ---------------------------------------------------------------
    // Main sequence and timeout
    // ---------------------------------------------------------------
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        repeat (5) @(posedge clk_i);
        locked_out();
        enable_port();
        config_io();
        flash_page();
        eeprom_io();
        lock_io();
        erase_all();
        end_session();
        print_verdict();
    end
endmodule : isp_port_tb_top
